/* rtc_link_pkg.sv */
// Purpose: Shared constants and state types for the two ends of the RTC two-wire slave link
// Assumes: 10 MHz mclk on both ends, open-drain lines with pull-ups resolved in the interface
// Notes: Identifier defaults are arbitrary values, overridden per instance
//
// Overview of operation
// - Device is slave; master drives clock always
// - Every byte is shifted MSB first
// - Data changes only while clock is low
// - Device leaves data released after power-up
// - Start condition begins everything; else ignored
// - Start ignored during power-up sequence
// - Stop ends operation; device returns to standby
// - Sender releases; receiver acks on ninth clock
// - Device acks identifier, address, write data; code refuses write data when buffer full
// - Master acks each read data byte but the last
// - Upper seven identifier bits select space
// - Direction bit: one reads, zero writes
// - Device acks only a matching identifier
// - Address byte or internal counter selects location
// - Address counter clears to zero at power-up
// - Random read reuses identical identifier
// - Memory space holds 128 bytes, 00h-7Fh
// - Write: start, id, address, data, stop
// - Read continues while master keeps acking
// - Pointer increments; register space wraps 2Fh
// - Port silent while running from backup supply
package rtc_link_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_QTR_NS = 625;
  localparam int QTR_CYC = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRUP_NS = 2000;
  localparam int PWRUP_CYC = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Arbitrary identifier values
  localparam logic [6:0] RTC_ID_DEF = 7'h35;
  localparam logic [6:0] MEM_ID_DEF = 7'h2c;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] REG_LAST = 8'h2f;
  localparam logic [7:0] SRAM_MASK = 8'h7f;
  localparam int SRAM_BYTES = 128;
  localparam int SRAM_AW = 7;
  localparam logic [3:0] ACK_CNT = 4'h8;
  localparam logic [3:0] MACK_CNT = 4'h9;
  localparam logic RW_READ = 1'b1;
  localparam int FIFO_DEPTH = 2;
  localparam int ENTRY_W = 17;
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ID = 3'b001,
    D_ADDR = 3'b010,
    D_WR = 3'b011,
    D_RD = 3'b100,
    D_WAIT = 3'b101
  } dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_START = 3'b001,
    H_ID = 3'b010,
    H_ADDR = 3'b011,
    H_WDATA = 3'b100,
    H_RDATA = 3'b101,
    H_STOP = 3'b110
  } host_state_t;
endpackage

/* rtc_link_if.sv */
// Purpose: Two-wire link between bus master end and RTC slave end
// Assumes: Both lines are open-drain with pull-ups; enable low means driving
// Notes: Master alone drives the clock line
`timescale 1ns/10ps
interface rtc_link_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_host_o;
  logic sda_host_oe_n;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic scl;
  logic sda;
  assign scl = scl_oe_n | scl_o;
  assign sda = (sda_host_oe_n | sda_host_o) & (sda_dev_oe_n | sda_dev_o);
  modport host (output scl_o, output scl_oe_n, output sda_host_o, output sda_host_oe_n, input scl, input sda);
  modport dev (output sda_dev_o, output sda_dev_oe_n, input scl, input sda);
endinterface // rtc_link_if

/* rtc_slave_end.sv */
// Purpose: RTC two-wire slave port with internal user SRAM and register-space access
// Assumes: Register space storage lives outside; reg_rdata follows reg_addr on mclk
// Notes: Every received write byte leaves through a small buffer; a full buffer refuses the byte
`timescale 1ns/10ps
module rtc_slave_end #(
  parameter logic [6:0] RTC_ID = rtc_link_pkg::RTC_ID_DEF,
  parameter logic [6:0] MEM_ID = rtc_link_pkg::MEM_ID_DEF,
  parameter int PWRUP_CYC = rtc_link_pkg::PWRUP_CYC,
  parameter int FIFO_DEPTH = rtc_link_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  rtc_link_if.dev link,
  input wire logic backup,
  output logic powerup_busy,
  output logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic wr_space_mem,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);
  localparam int PW = $clog2(PWRUP_CYC + 1);
  localparam int FP = $clog2(FIFO_DEPTH);
  localparam int FC = $clog2(FIFO_DEPTH + 1);
  localparam int EW = rtc_link_pkg::ENTRY_W;

  typedef struct packed {
    rtc_link_pkg::dev_state_t st;
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic bak_m;
    logic bak_s;
    logic [PW-1:0] pu_cnt;
    logic pu_busy;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic ackph;
    logic mack;
    logic rd;
    logic mem;
    logic [7:0] ptr;
    logic oe_n;
    logic [rtc_link_pkg::SRAM_BYTES-1:0][7:0] sram;
    logic [FIFO_DEPTH-1:0][EW-1:0] fmem;
    logic [FP-1:0] wp;
    logic [FP-1:0] rp;
    logic [FC-1:0] cnt;
    logic fval;
    logic [EW-1:0] fout;
  } dev_reg_t;

  dev_reg_t q;
  dev_reg_t d;

  function automatic logic [7:0] next_ptr(input logic [7:0] p, input logic m);
    if (m) begin
      return (p + 8'h01) & rtc_link_pkg::SRAM_MASK;
    end
    return (p == rtc_link_pkg::REG_LAST) ? rtc_link_pkg::ADDR_RESET : p + 8'h01;
  endfunction

  function automatic logic [FP-1:0] fifo_next(input logic [FP-1:0] p);
    return (p == FP'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic id_rtc;
    logic id_mem;
    logic full;
    logic [7:0] rbyte;
    d = q;
    rise = q.scl_s & ~q.scl_p;
    fall = ~q.scl_s & q.scl_p;
    start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    stop = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    id_rtc = (q.sh[7:1] == RTC_ID);
    id_mem = (q.sh[7:1] == MEM_ID);
    rbyte = q.mem ? q.sram[q.ptr[rtc_link_pkg::SRAM_AW-1:0]] : reg_rdata;
    // Line and supply inputs are foreign to mclk
    d.scl_m = link.scl;
    d.scl_s = q.scl_m;
    d.scl_p = q.scl_s;
    d.sda_m = link.sda;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;
    d.bak_m = backup;
    d.bak_s = q.bak_m;
    if (q.pu_busy) begin
      if (q.pu_cnt == PW'(PWRUP_CYC - 1)) begin
        d.pu_busy = 1'b0;
      end else begin
        d.pu_cnt = q.pu_cnt + 1'b1;
      end
    end
    if (q.fval && wr_ready) begin
      d.rp = fifo_next(q.rp);
      d.cnt = q.cnt - 1'b1;
    end
    full = (d.cnt == FC'(FIFO_DEPTH));
    case (q.st)
      rtc_link_pkg::D_ID, rtc_link_pkg::D_ADDR, rtc_link_pkg::D_WR: begin
        if (rise && !q.ackph && q.bitcnt != rtc_link_pkg::ACK_CNT) begin
          d.sh = {q.sh[6:0], q.sda_s};
          d.bitcnt = q.bitcnt + 4'h1;
        end else if (fall && q.ackph) begin
          // Ack ends on the falling clock so the line moves only while low
          d.ackph = 1'b0;
          d.bitcnt = 4'h0;
          d.oe_n = 1'b1;
          if (q.st == rtc_link_pkg::D_ID && q.rd == rtc_link_pkg::RW_READ) begin
            d.st = rtc_link_pkg::D_RD;
            d.sh = rbyte;
            d.oe_n = rbyte[7];
            d.ptr = next_ptr(q.ptr, q.mem);
          end else if (q.st == rtc_link_pkg::D_ID) begin
            d.st = rtc_link_pkg::D_ADDR;
          end else begin
            d.st = rtc_link_pkg::D_WR;
          end
        end else if (fall && !q.ackph && q.bitcnt == rtc_link_pkg::ACK_CNT) begin
          if (q.st == rtc_link_pkg::D_ID) begin
            if (id_rtc || id_mem) begin
              d.ackph = 1'b1;
              d.oe_n = 1'b0;
              d.rd = q.sh[0];
              d.mem = id_mem;
            end else begin
              d.st = rtc_link_pkg::D_WAIT;
            end
          end else if (q.st == rtc_link_pkg::D_ADDR) begin
            d.ptr = q.sh;
            d.ackph = 1'b1;
            d.oe_n = 1'b0;
          end else if (!full) begin
            d.fmem[q.wp] = {q.mem, q.ptr, q.sh};
            d.wp = fifo_next(q.wp);
            d.cnt = d.cnt + 1'b1;
            if (q.mem) begin
              d.sram[q.ptr[rtc_link_pkg::SRAM_AW-1:0]] = q.sh;
            end
            d.ptr = next_ptr(q.ptr, q.mem);
            d.ackph = 1'b1;
            d.oe_n = 1'b0;
          end else begin
            // No room downstream: refuse the byte rather than lose it
            d.st = rtc_link_pkg::D_WAIT;
          end
        end
      end
      rtc_link_pkg::D_RD: begin
        if (rise) begin
          if (q.bitcnt == rtc_link_pkg::ACK_CNT) begin
            d.mack = ~q.sda_s;
          end
          d.bitcnt = q.bitcnt + 4'h1;
        end else if (fall) begin
          if (q.bitcnt == rtc_link_pkg::MACK_CNT) begin
            if (q.mack) begin
              d.sh = rbyte;
              d.oe_n = rbyte[7];
              d.ptr = next_ptr(q.ptr, q.mem);
              d.bitcnt = 4'h0;
            end else begin
              d.st = rtc_link_pkg::D_WAIT;
              d.oe_n = 1'b1;
            end
          end else if (q.bitcnt == rtc_link_pkg::ACK_CNT) begin
            d.oe_n = 1'b1;
          end else if (q.bitcnt != 4'h0) begin
            d.sh = {q.sh[6:0], 1'b0};
            d.oe_n = q.sh[6];
          end
        end
      end
      rtc_link_pkg::D_IDLE, rtc_link_pkg::D_WAIT: begin
        d.oe_n = 1'b1;
      end
      default: begin
        d.st = rtc_link_pkg::D_IDLE;
        d.oe_n = 1'b1;
      end
    endcase
    if (start && !q.pu_busy) begin
      d.st = rtc_link_pkg::D_ID;
      d.bitcnt = 4'h0;
      d.ackph = 1'b0;
      d.oe_n = 1'b1;
    end
    if (stop) begin
      d.st = rtc_link_pkg::D_IDLE;
      d.ackph = 1'b0;
      d.oe_n = 1'b1;
    end
    if (q.bak_s) begin
      d.st = rtc_link_pkg::D_IDLE;
      d.ackph = 1'b0;
      d.oe_n = 1'b1;
    end
    d.fval = (d.cnt != '0);
    d.fout = d.fmem[d.rp];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.oe_n <= 1'b1;
      q.pu_busy <= 1'b1;
      q.ptr <= rtc_link_pkg::ADDR_RESET;
      q.scl_m <= 1'b1;
      q.scl_s <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.sda_p <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Open-drain: only ever pulls low, never drives the clock
  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe_n = q.oe_n;
  assign powerup_busy = q.pu_busy;
  assign reg_addr = q.ptr;
  assign wr_valid = q.fval;
  assign wr_space_mem = q.fout[EW-1];
  assign wr_addr = q.fout[15:8];
  assign wr_data = q.fout[7:0];
endmodule // rtc_slave_end

/* rtc_master_end.sv */
// Purpose: Two-wire bus master end issuing writes and random or current-address reads
// Assumes: One command at a time; cmd_len at least one for reads
// Notes: Clock is a divider of mclk, four quarters per bit, no clock stretching
`timescale 1ns/10ps
module rtc_master_end #(
  parameter int QTR_CYC = rtc_link_pkg::QTR_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  rtc_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic cmd_set_addr,
  input wire logic [6:0] cmd_id,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_len,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic nack
);
  localparam int TW = $clog2(QTR_CYC + 1);

  typedef struct packed {
    rtc_link_pkg::host_state_t st;
    logic [1:0] ph;
    logic [TW-1:0] tick;
    logic [3:0] bits;
    logic [8:0] tx;
    logic [8:0] rx;
    logic scl_oe_n;
    logic sda_oe_n;
    logic sda_m;
    logic sda_s;
    logic rd;
    logic rphase;
    logic [6:0] id;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] left;
    logic rv;
    logic [7:0] rdat;
    logic done;
    logic nack;
    logic rdy;
  } host_reg_t;

  host_reg_t q;
  host_reg_t d;

  always_comb begin
    logic step;
    logic last;
    logic [8:0] rxb;
    d = q;
    step = (q.tick == TW'(QTR_CYC - 1));
    last = step && (q.ph == 2'b11);
    rxb = {q.rx[7:0], q.sda_s};
    d.sda_m = link.sda;
    d.sda_s = q.sda_m;
    d.rv = 1'b0;
    d.done = 1'b0;
    if (q.st != rtc_link_pkg::H_IDLE) begin
      d.tick = step ? '0 : q.tick + 1'b1;
      if (step) begin
        d.ph = q.ph + 2'b01;
      end
    end
    case (q.st)
      rtc_link_pkg::H_IDLE: begin
        if (cmd_valid && q.rdy) begin
          d.rdy = 1'b0;
          d.nack = 1'b0;
          d.rd = cmd_read;
          d.rphase = cmd_read && !cmd_set_addr;
          d.id = cmd_id;
          d.addr = cmd_addr;
          d.wdata = cmd_wdata;
          d.left = cmd_len;
          d.st = rtc_link_pkg::H_START;
          d.ph = 2'b00;
          d.tick = '0;
        end
      end
      rtc_link_pkg::H_START: begin
        if (last) begin
          d.st = rtc_link_pkg::H_ID;
          d.bits = 4'h0;
          d.tx = {q.id, q.rphase, 1'b1};
        end
      end
      rtc_link_pkg::H_ID, rtc_link_pkg::H_ADDR, rtc_link_pkg::H_WDATA, rtc_link_pkg::H_RDATA: begin
        if (last) begin
          d.rx = rxb;
          d.tx = {q.tx[7:0], 1'b1};
          d.bits = q.bits + 4'h1;
          if (q.bits == rtc_link_pkg::ACK_CNT) begin
            d.bits = 4'h0;
            if (q.st != rtc_link_pkg::H_RDATA && rxb[0]) begin
              d.nack = 1'b1;
              d.st = rtc_link_pkg::H_STOP;
            end else if (q.st == rtc_link_pkg::H_ID && q.rphase) begin
              d.st = rtc_link_pkg::H_RDATA;
              d.tx = {8'hff, q.left == 8'h01};
            end else if (q.st == rtc_link_pkg::H_ID) begin
              d.st = rtc_link_pkg::H_ADDR;
              d.tx = {q.addr, 1'b1};
            end else if (q.st == rtc_link_pkg::H_ADDR && q.rd) begin
              d.rphase = 1'b1;
              d.st = rtc_link_pkg::H_START;
            end else if (q.st == rtc_link_pkg::H_ADDR) begin
              d.st = rtc_link_pkg::H_WDATA;
              d.tx = {q.wdata, 1'b1};
            end else if (q.st == rtc_link_pkg::H_WDATA) begin
              d.st = rtc_link_pkg::H_STOP;
            end else begin
              d.rv = 1'b1;
              d.rdat = rxb[8:1];
              d.left = q.left - 8'h01;
              if (q.left == 8'h01) begin
                d.st = rtc_link_pkg::H_STOP;
              end else begin
                d.tx = {8'hff, q.left == 8'h02};
              end
            end
          end
        end
      end
      rtc_link_pkg::H_STOP: begin
        if (last) begin
          d.st = rtc_link_pkg::H_IDLE;
          d.done = 1'b1;
          d.rdy = 1'b1;
        end
      end
      default: begin
        d.st = rtc_link_pkg::H_IDLE;
        d.rdy = 1'b1;
      end
    endcase
    // Line levels follow state and quarter; data bits move only in the low quarters, start and stop edges in a high one
    case (d.st)
      rtc_link_pkg::H_START: begin
        // A repeated start pulls the clock low first, so the slave can drop its acknowledge
        if (d.ph != 2'b00) begin
          d.scl_oe_n = (d.ph != 2'b11);
        end else if (q.st != rtc_link_pkg::H_START) begin
          d.scl_oe_n = (q.st == rtc_link_pkg::H_IDLE);
        end else begin
          d.scl_oe_n = q.scl_oe_n;
        end
        d.sda_oe_n = (d.ph < 2'b10);
      end
      rtc_link_pkg::H_STOP: begin
        d.scl_oe_n = (d.ph != 2'b00);
        d.sda_oe_n = (d.ph >= 2'b10);
      end
      rtc_link_pkg::H_IDLE: begin
        d.scl_oe_n = 1'b1;
        d.sda_oe_n = 1'b1;
      end
      default: begin
        d.scl_oe_n = (d.ph >= 2'b10);
        d.sda_oe_n = d.tx[8];
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.scl_oe_n <= 1'b1;
      q.sda_oe_n <= 1'b1;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.scl_o = 1'b0;
  assign link.scl_oe_n = q.scl_oe_n;
  assign link.sda_host_o = 1'b0;
  assign link.sda_host_oe_n = q.sda_oe_n;
  assign cmd_ready = q.rdy;
  assign rd_valid = q.rv;
  assign rd_data = q.rdat;
  assign done = q.done;
  assign nack = q.nack;
endmodule // rtc_master_end

/* rtc_link_asserts.sv */
// Purpose: Protocol checker on the two-wire link between the master end and the slave end
// Assumes: Lines resolved in rtc_link_if, sampled on mclk
// Notes: Bit and byte position are tracked from start conditions seen on the wires
`timescale 1ns/10ps
module rtc_link_asserts #(
  parameter logic [6:0] RTC_ID = rtc_link_pkg::RTC_ID_DEF,
  parameter logic [6:0] MEM_ID = rtc_link_pkg::MEM_ID_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_o,
  input wire logic sda_host_o,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe_n,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, rd_q, nak_q, act_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q;
  logic rise, start, stop, id_ok;
  assign rise = !scl_q && scl;
  assign start = scl_q && scl && sda_q && !sda;
  assign stop = scl_q && scl && !sda_q && sda;
  assign id_ok = (sh_q[7:1] == RTC_ID) || (sh_q[7:1] == MEM_ID);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rd_q <= 1'b0;
      nak_q <= 1'b0;
      act_q <= 1'b0;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      sh_q <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        bit_q <= 4'h0;
        byte_q <= 2'h0;
        nak_q <= 1'b0;
        act_q <= 1'b1;
      end else if (rise) begin
        bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
        if (bit_q < 4'h8) sh_q <= {sh_q[6:0], sda};
        if (bit_q == 4'h7 && byte_q == 2'h0) rd_q <= sda;
        if (bit_q == 4'h8 && byte_q != 2'h3) byte_q <= byte_q + 2'h1;
        if (bit_q == 4'h8 && rd_q && byte_q != 2'h0) nak_q <= sda;
      end
      if (stop) act_q <= 1'b0;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  reset_release_a: assert property ($rose(rst_n) |-> sda_dev_oe_n)
    else $error("slave drives data line right after reset");
  open_drain_a: assert property (!scl_o && !sda_host_o && !sda_dev_o)
    else $error("a line is driven high instead of released");
  dev_stable_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe_n))
    else $error("slave changed data line while clock high");
  idle_silent_a: assert property (!act_q |-> sda_dev_oe_n)
    else $error("slave drives data line outside a transfer");
  id_ack_a: assert property (rise && bit_q == 4'h8 && byte_q == 2'h0 && !sda_dev_oe_n |-> id_ok)
    else $error("slave acknowledged a foreign identifier");
  rx_release_a: assert property (rise && bit_q < 4'h8 && !(rd_q && byte_q != 2'h0) |-> sda_dev_oe_n)
    else $error("slave drives data line while receiving");
  mack_release_a: assert property (rise && bit_q == 4'h8 && rd_q && byte_q != 2'h0 |-> sda_dev_oe_n)
    else $error("slave drives data line in master acknowledge slot");
  nack_release_a: assert property (nak_q && $fell(scl) |-> ##[1:5] sda_dev_oe_n [*8])
    else $error("slave kept sending after master no-acknowledge");
endmodule // rtc_link_asserts

/* rtc_i2c_slave_access_test.sv */
// Purpose: Self-checking bench joining master end and slave end over rtc_link_if
// Assumes: Register space modelled as address xor a5h on reg_rdata
// Notes: Write entries are checked at the buffer pop; reads against a bench memory model
`timescale 1ns/10ps
module rtc_i2c_slave_access_test;
  localparam logic [6:0] RID = rtc_link_pkg::RTC_ID_DEF;
  localparam logic [6:0] MID = rtc_link_pkg::MEM_ID_DEF;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_set_addr = 1'b0;
  logic [6:0] cmd_id = 7'h00;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [7:0] cmd_len = 8'h01;
  logic backup = 1'b0;
  logic wr_ready = 1'b1;
  logic stall = 1'b0;
  logic cmd_ready, rd_valid, done, nack, powerup_busy, wr_valid, wr_space_mem;
  logic [7:0] rd_data, reg_addr, reg_rdata, wr_addr, wr_data;
  logic [7:0] sram [128];
  logic [16:0] exp_q [$];
  logic [7:0] rdq [$];
  int bad_count = 0;
  int checks = 0;
  rtc_link_if link ();
  always #50 mclk = ~mclk;
  assign reg_rdata = reg_addr ^ 8'ha5;
  rtc_master_end i_rtc_master_end (.mclk(mclk), .rst_n(rst_n), .link(link.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_set_addr(cmd_set_addr), .cmd_id(cmd_id), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_len(cmd_len), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack));
  rtc_slave_end i_rtc_slave_end (.mclk(mclk), .rst_n(rst_n), .link(link.dev), .backup(backup),
    .powerup_busy(powerup_busy), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_space_mem(wr_space_mem), .wr_addr(wr_addr), .wr_data(wr_data));
  rtc_link_asserts i_rtc_link_asserts (.mclk(mclk), .rst_n(rst_n), .scl_o(link.scl_o), .sda_host_o(link.sda_host_o),
    .sda_dev_o(link.sda_dev_o), .sda_dev_oe_n(link.sda_dev_oe_n), .scl(link.scl), .sda(link.sda));
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_ent(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Consumer stalls at random so the buffer really holds entries
  always @(posedge mclk) begin
    #10;
    wr_ready = stall ? 1'b0 : 1'($urandom_range(0, 1));
  end
  always @(posedge mclk) begin
    if (rst_n && wr_valid === 1'b1 && wr_ready === 1'b1)
      cmp_ent({wr_space_mem, wr_addr, wr_data}, exp_q.size() ? exp_q.pop_front() : 17'h1ffff);
  end
  task automatic run(input logic rd, input logic sa, input logic [6:0] id, input logic [7:0] ad,
                     input logic [7:0] wd, input logic [7:0] ln);
    int n;
    @(posedge mclk);
    #10;
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_set_addr = sa;
    cmd_id = id;
    cmd_addr = ad;
    cmd_wdata = wd;
    cmd_len = ln;
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    #10;
    cmd_valid = 1'b0;
    rdq.delete();
    n = 0;
    do begin
      @(negedge mclk);
      n++;
      if (rd_valid === 1'b1) rdq.push_back(rd_data);
    end while (done !== 1'b1 && n < 8000);
    cmp_flag(done, 1'b1);
  endtask
  // Expected entry is queued first: the buffer may pop long before the stop
  task automatic wr(input logic [6:0] id, input logic [7:0] a, input logic [7:0] d, input logic ok);
    if (ok && id == MID) sram[a[6:0]] = d;
    if (ok) exp_q.push_back({id == MID, a, d});
    run(1'b0, 1'b1, id, a, d, 8'h01);
    cmp_flag(nack, !ok);
  endtask
  // Register space is modelled as address xor a5h, memory space by the bench copy
  function automatic logic [7:0] exp_rd(input logic mem, input logic [7:0] p);
    return mem ? sram[p[6:0]] : p ^ 8'ha5;
  endfunction
  task automatic rd(input logic mem, input logic sa, input logic [7:0] a, input logic [7:0] ln);
    logic [7:0] p;
    p = a;
    run(1'b1, sa, mem ? MID : RID, a, 8'h00, ln);
    cmp_byte(8'(rdq.size()), ln);
    foreach (rdq[i]) begin
      cmp_byte(rdq[i], exp_rd(mem, p));
      p = mem ? ((p + 8'h01) & 8'h7f) : (p == 8'h2f ? 8'h00 : p + 8'h01);
    end
  endtask
  initial begin
    logic [7:0] a;
    void'($urandom(32'h150c));
    foreach (sram[i]) sram[i] = 8'h00;
    repeat (4) @(posedge mclk);
    #10;
    rst_n = 1'b1;
    cmp_flag(powerup_busy, 1'b1);
    wr(MID, 8'h10, 8'h99, 1'b0);
    cmp_flag(powerup_busy, 1'b0);
    rd(1'b0, 1'b0, 8'h00, 8'h03);
    rd(1'b0, 1'b1, 8'h2e, 8'h03);
    wr(MID, 8'h7f, 8'h3c, 1'b1);
    wr(MID, 8'h00, 8'hc3, 1'b1);
    rd(1'b1, 1'b1, 8'h7f, 8'h02);
    wr(RID, 8'h05, 8'h77, 1'b1);
    wr(7'h11, 8'h01, 8'h01, 1'b0);
    @(posedge mclk);
    #10;
    backup = 1'b1;
    wr(MID, 8'h20, 8'h55, 1'b0);
    @(posedge mclk);
    #10;
    backup = 1'b0;
    repeat (4) @(posedge mclk);
    stall = 1'b1;
    wr(MID, 8'h30, 8'h01, 1'b1);
    wr(MID, 8'h31, 8'h02, 1'b1);
    wr(MID, 8'h32, 8'h03, 1'b0);
    stall = 1'b0;
    repeat (6) begin
      a = 8'($urandom_range(0, 127));
      wr(MID, a, 8'($urandom), 1'b1);
      rd(1'b1, 1'b1, a, 8'($urandom_range(1, 3)));
      rd(1'b0, 1'b1, 8'($urandom_range(0, 47)), 8'($urandom_range(1, 4)));
    end
    repeat (20) @(posedge mclk);
    cmp_byte(8'(exp_q.size()), 8'h00);
    end_of_test();
  end
  // About three times the expected length of the whole sequence
  initial begin
    #(100000 * 100);
    bad_count++;
    end_of_test();
  end
endmodule // rtc_i2c_slave_access_test
